// >>> core/loop_cal_map.svh
// What this block does
// - ramp-up uses robust compensation from bits 15:0
// - calibration enabled: inject signal after ramp-up
// - pole choice from switching, resonance, output level
// - completed calibration overwrites filter model 15:0
// - output disable restores resonance from nonvolatile copy
// - calibration off keeps ramp-up resonance afterwards
// - policy bit 2 saves settings after calibration
// - policy 0x024B calibrates once per ramp-up
// - policy 0x124B calibrates after first ramp-up only
// - policy 0x034B recalibrates about every 800 ms
// - policy 0x004B never calibrates, uses stored value
// - policy bit 8 starts/stops continuous calibration live
// - open-loop gain follows loop gain factor
// - defaults gain 0.5, damping 1.5, 10% bandwidth
// - loop options enable negative duty cycle
// - settings change through commands, policy and filter model defaults from memory
`ifndef LOOP_CAL_MAP_SVH
`define LOOP_CAL_MAP_SVH
// command codes of the settings port
`define CMD_CAL_POLICY     8'hD0
`define CMD_FILTER_MODEL   8'hD1
`define CMD_LOOP_GAIN      8'hD2
`define CMD_DAMPING        8'hD3
`define CMD_LOOP_OPTIONS   8'hD4
`define CMD_SWITCH_FREQ    8'hD5
// reset values; gain and damping are unsigned 8.8 fixed point
`define CAL_POLICY_RESET   16'h024B
`define LOOP_GAIN_RESET    16'h0080
`define DAMPING_RESET      16'h0180
`define LOOP_OPTIONS_RESET 16'h0000
`define SWITCH_FREQ_RESET  16'h0258
`define BANDWIDTH_PCT      8'h0A
// policy and option field positions
`define POL_AUTOSAVE_BIT   2
`define POL_CONTINUOUS_BIT 8
`define POL_ENABLE_BIT     9
`define POL_FIRST_ONLY_BIT 12
`define OPT_NEG_DUTY_BIT   0
`define RES_FREQ_MSB       15
// timing
`define MCLK_HZ            100000000
`define CAL_INTERVAL_MS    800
`define CAL_INTERVAL_CYCLES (`CAL_INTERVAL_MS * (`MCLK_HZ / 1000))
`endif

// >>> core/loop_cal_pkg.sv
package loop_cal_pkg;
  // calibration sequencer, gray along off-ramp-measure-run-wait
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_RAMP    = 3'b001,
    ST_MEASURE = 3'b011,
    ST_RUN     = 3'b010,
    ST_WAIT    = 3'b110
  } cal_state_type;
endpackage : loop_cal_pkg

// >>> core/cal_interval_timer.sv
`timescale 1ns/10ps
module cal_interval_timer #(
  parameter int unsigned LIMIT = 80000000 // cycles between pulses
) (
  input  wire logic mclk,    // system clock
  input  wire logic reset_n, // synchronous reset, active low
  input  wire logic run,     // count while high, clear while low
  output logic      expire   // one-cycle pulse each LIMIT cycles
);
  logic [26:0] count_q;
  logic [26:0] count_d;
  logic        last;

  // restarting from zero keeps intervals even under continuous mode
  assign last    = (count_q == 27'(LIMIT - 1));
  assign count_d = (!run || last) ? 27'h0000000 : count_q + 27'h0000001;

  ////////////////////////////////////////////////////////////////////
  // counter
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_q <= 27'h0000000;
      expire  <= 1'b0;
    end else begin
      count_q <= count_d;
      expire  <= run && last;
    end
  end
endmodule : cal_interval_timer

// >>> core/loop_compensation_calibration.sv
`timescale 1ns/10ps
`include "loop_cal_map.svh"
module loop_compensation_calibration #(
  parameter int unsigned INTERVAL_CYCLES = `CAL_INTERVAL_CYCLES // recalibration period
) (
  input  wire logic                         mclk,           // 100 MHz clock
  input  wire logic                         reset_n,        // sync reset, input power applied
  input  wire logic                         cmd_wr,         // settings write strobe
  input  wire logic                         cmd_rd,         // settings read strobe
  input  wire logic [7:0]                   cmd_code,       // settings command code
  input  wire logic [31:0]                  cmd_wdata,      // write data
  output logic      [31:0]                  cmd_rdata,      // read data, registered
  output logic                              cmd_rvalid,     // read data valid pulse
  output logic                              cmd_unknown,    // unmapped code pulse
  input  wire logic [31:0]                  nvm_filter_model, // stored filter model copy
  input  wire logic [15:0]                  nvm_cal_policy, // stored policy default
  input  wire logic                         nvm_load,       // load defaults pulse
  input  wire logic                         output_enable,  // output enabled level
  input  wire logic                         rampup_done,    // ramp-up finished pulse
  input  wire logic                         meas_done,      // measurement finished pulse
  input  wire logic [15:0]                  meas_freq,      // measured resonance
  output logic                              inject_en,      // ac measurement signal on
  output logic                              robust_comp,    // low-bandwidth ramp-up gains
  output logic                              pole_update,    // recompute poles pulse
  output logic      [15:0]                  output_resonance_freq, // resonance in use
  output logic      [15:0]                  switching_frequency,   // switching setting
  output logic      [15:0]                  loop_gain,      // open-loop gain factor
  output logic      [15:0]                  damping_ratio_setting, // closed-loop damping
  output logic      [7:0]                   bandwidth_pct,  // bandwidth target
  output logic                              neg_duty_en,    // negative duty cycle on
  output logic                              nvm_store_req,  // save-all pulse
  output loop_cal_pkg::cal_state_type       cal_state       // sequencer state
);
  import loop_cal_pkg::*;

  logic [15:0]   cal_policy_q;
  logic [31:0]   filter_model_q;
  logic [15:0]   loop_gain_q;
  logic [15:0]   damping_q;
  logic [15:0]   loop_options_q;
  logic [15:0]   switch_freq_q;
  logic          first_done_q;
  logic          enable_q;
  cal_state_type state_q;
  cal_state_type state_d;
  logic          interval_hit;

  ////////////////////////////////////////////////////////////////////
  // decode of commands and policy
  wire wr_policy  = cmd_wr && (cmd_code == `CMD_CAL_POLICY);
  wire wr_model   = cmd_wr && (cmd_code == `CMD_FILTER_MODEL);
  wire wr_gain    = cmd_wr && (cmd_code == `CMD_LOOP_GAIN);
  wire wr_damp    = cmd_wr && (cmd_code == `CMD_DAMPING);
  wire wr_opts    = cmd_wr && (cmd_code == `CMD_LOOP_OPTIONS);
  wire wr_fsw     = cmd_wr && (cmd_code == `CMD_SWITCH_FREQ);
  wire code_known = (cmd_code >= `CMD_CAL_POLICY) && (cmd_code <= `CMD_SWITCH_FREQ);
  wire pol_cont   = cal_policy_q[`POL_CONTINUOUS_BIT];
  // continuous bit alone also counts as enabled, so bit 8 works live
  wire pol_enable = cal_policy_q[`POL_ENABLE_BIT] || pol_cont;
  wire pol_first  = cal_policy_q[`POL_FIRST_ONLY_BIT];
  wire pol_save   = cal_policy_q[`POL_AUTOSAVE_BIT];
  wire disable_ev = enable_q && !output_enable;
  wire ramp_cal   = pol_enable && !(pol_first && first_done_q && !pol_cont);
  wire cal_done   = (state_q == ST_MEASURE) && meas_done;

  ////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (output_enable) state_d = ST_RAMP;
      end
      ST_RAMP: begin
        if (rampup_done) state_d = ramp_cal ? ST_MEASURE : ST_RUN;
      end
      ST_MEASURE: begin
        if (meas_done) state_d = pol_cont ? ST_WAIT : ST_RUN;
      end
      ST_RUN: begin
        if (pol_cont) state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (!pol_cont) state_d = ST_RUN;
        else if (interval_hit) state_d = ST_MEASURE;
      end
      default: state_d = ST_OFF;
    endcase
    if (!output_enable) state_d = ST_OFF;
  end

  cal_interval_timer #(
    .LIMIT (INTERVAL_CYCLES)
  ) u_interval (
    .mclk    (mclk),
    .reset_n (reset_n),
    .run     (state_q == ST_WAIT),
    .expire  (interval_hit)
  );

  ////////////////////////////////////////////////////////////////////
  // sequencer and power-up memory
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q      <= ST_OFF;
      enable_q     <= 1'b0;
      first_done_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      enable_q <= output_enable;
      if (cal_done) first_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // settings; hardware updates win over a host write in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cal_policy_q   <= `CAL_POLICY_RESET;
      filter_model_q <= 32'h00000000;
      loop_gain_q    <= `LOOP_GAIN_RESET;
      damping_q      <= `DAMPING_RESET;
      loop_options_q <= `LOOP_OPTIONS_RESET;
      switch_freq_q  <= `SWITCH_FREQ_RESET;
    end else begin
      if (nvm_load) begin
        cal_policy_q   <= nvm_cal_policy;
        filter_model_q <= nvm_filter_model;
      end else begin
        if (wr_policy) cal_policy_q <= cmd_wdata[15:0];
        if (wr_model) filter_model_q <= cmd_wdata;
        // the save request consumes bit 2
        if (cal_done && pol_save) cal_policy_q[`POL_AUTOSAVE_BIT] <= 1'b0;
        if (cal_done) filter_model_q[`RES_FREQ_MSB:0] <= meas_freq;
        if (disable_ev) filter_model_q[`RES_FREQ_MSB:0] <= nvm_filter_model[15:0];
      end
      if (wr_gain) loop_gain_q <= cmd_wdata[15:0];
      if (wr_damp) damping_q <= cmd_wdata[15:0];
      if (wr_opts) loop_options_q <= cmd_wdata[15:0];
      if (wr_fsw) switch_freq_q <= cmd_wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read-back mux
  wire [31:0] rd_mux = (cmd_code == `CMD_CAL_POLICY)   ? {16'h0000, cal_policy_q} :
                       (cmd_code == `CMD_FILTER_MODEL) ? filter_model_q :
                       (cmd_code == `CMD_LOOP_GAIN)    ? {16'h0000, loop_gain_q} :
                       (cmd_code == `CMD_DAMPING)      ? {16'h0000, damping_q} :
                       (cmd_code == `CMD_LOOP_OPTIONS) ? {16'h0000, loop_options_q} :
                       (cmd_code == `CMD_SWITCH_FREQ)  ? {16'h0000, switch_freq_q} :
                                                         32'h00000000;

  ////////////////////////////////////////////////////////////////////
  // outputs toward the control law, all registered
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmd_rdata             <= 32'h00000000;
      cmd_rvalid            <= 1'b0;
      cmd_unknown           <= 1'b0;
      inject_en             <= 1'b0;
      robust_comp           <= 1'b0;
      pole_update           <= 1'b0;
      output_resonance_freq <= 16'h0000;
      switching_frequency   <= `SWITCH_FREQ_RESET;
      loop_gain             <= `LOOP_GAIN_RESET;
      damping_ratio_setting <= `DAMPING_RESET;
      bandwidth_pct         <= `BANDWIDTH_PCT;
      neg_duty_en           <= 1'b0;
      nvm_store_req         <= 1'b0;
    end else begin
      cmd_rdata             <= cmd_rd ? rd_mux : cmd_rdata;
      cmd_rvalid            <= cmd_rd;
      cmd_unknown           <= (cmd_rd || cmd_wr) && !code_known;
      inject_en             <= (state_d == ST_MEASURE);
      robust_comp           <= (state_d == ST_RAMP);
      // poles are recomputed at the end of ramp-up and after each completed calibration
      pole_update           <= cal_done || (state_q == ST_RAMP && rampup_done);
      output_resonance_freq <= filter_model_q[`RES_FREQ_MSB:0];
      switching_frequency   <= switch_freq_q;
      loop_gain             <= loop_gain_q;
      damping_ratio_setting <= damping_q;
      bandwidth_pct         <= `BANDWIDTH_PCT;
      neg_duty_en           <= loop_options_q[`OPT_NEG_DUTY_BIT];
      nvm_store_req         <= cal_done && pol_save;
    end
  end

  assign cal_state = state_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_ramp_robust;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ST_RAMP && output_enable && !rampup_done) |-> ##1 robust_comp;
  endproperty
  a_ramp_robust: assert property (p_ramp_robust) else $error("ramp without robust gains");

  property p_inject_after_ramp;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ST_RAMP && rampup_done && output_enable && ramp_cal) |-> ##1 inject_en;
  endproperty
  a_inject_after_ramp: assert property (p_inject_after_ramp) else $error("no injection");

  property p_result_written;
    @(posedge mclk) disable iff (!reset_n)
      (cal_done && !nvm_load && !disable_ev) |=> (filter_model_q[15:0] == $past(meas_freq));
  endproperty
  a_result_written: assert property (p_result_written) else $error("result not stored");

  property p_restore_on_disable;
    @(posedge mclk) disable iff (!reset_n)
      (disable_ev && !nvm_load) |=> (filter_model_q[15:0] == $past(nvm_filter_model[15:0]));
  endproperty
  a_restore_on_disable: assert property (p_restore_on_disable) else $error("no restore");

  property p_autosave;
    @(posedge mclk) disable iff (!reset_n)
      (cal_done && pol_save) |-> ##1 nvm_store_req ##1 !nvm_store_req;
  endproperty
  a_autosave: assert property (p_autosave) else $error("save not one pulse");

  property p_disabled_no_cal;
    @(posedge mclk) disable iff (!reset_n)
      (!pol_enable && state_q == ST_RAMP && rampup_done && output_enable)
        |=> (state_q == ST_RUN) ##1 !inject_en;
  endproperty
  a_disabled_no_cal: assert property (p_disabled_no_cal) else $error("calibrated while off");

  property p_first_only;
    @(posedge mclk) disable iff (!reset_n)
      (pol_first && !pol_cont && first_done_q && rampup_done && state_q == ST_RAMP)
        |=> (state_q != ST_MEASURE);
  endproperty
  a_first_only: assert property (p_first_only) else $error("repeat after first");

  property p_cont_follow;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ST_WAIT && !pol_cont && output_enable) |=> (state_q == ST_RUN);
  endproperty
  a_cont_follow: assert property (p_cont_follow) else $error("continuous not stopped");

  property p_interval;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ST_WAIT && interval_hit && pol_cont && output_enable)
        |=> (state_q == ST_MEASURE) && inject_en;
  endproperty
  a_interval: assert property (p_interval) else $error("interval missed");

  property p_gain_follows;
    @(posedge mclk) disable iff (!reset_n)
      wr_gain |-> ##2 (loop_gain == $past(cmd_wdata[15:0], 2));
  endproperty
  a_gain_follows: assert property (p_gain_follows) else $error("gain not applied");
endmodule : loop_compensation_calibration

// >>> testbench/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic        mclk,       // system clock
  output logic             cmd_wr,     // write strobe
  output logic             cmd_rd,     // read strobe
  output logic [7:0]       cmd_code,   // command code
  output logic [31:0]      cmd_wdata,  // write data
  input  wire logic [31:0] cmd_rdata,  // read data
  input  wire logic        cmd_rvalid  // read data valid
);
  // idle code and data lines flip, so a stale value never looks like a held request
  initial begin
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_code  = 8'hFF;
    cmd_wdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle write, released just after the taking edge
  task automatic write_cmd(input logic [7:0] code, input logic [31:0] data);
    @(posedge mclk);
    cmd_wr    <= 1'b1;
    cmd_code  <= code;
    cmd_wdata <= data;
    @(posedge mclk);
    cmd_wr    <= 1'b0;
    cmd_code  <= ~code;
    cmd_wdata <= ~data;
  endtask : write_cmd

  // read answer stands one cycle, so it is taken right after it lands
  task automatic read_cmd(input logic [7:0] code, output logic [31:0] data);
    @(posedge mclk);
    cmd_rd   <= 1'b1;
    cmd_code <= code;
    @(posedge mclk);
    cmd_rd   <= 1'b0;
    cmd_code <= ~code;
    #1;
    data = (cmd_rvalid === 1'b1) ? cmd_rdata : 32'hDEADBEEF;
  endtask : read_cmd
endmodule : host_model

// >>> testbench/loop_compensation_calibration_tb_top.sv
`timescale 1ns/10ps
`include "loop_cal_map.svh"
module loop_compensation_calibration_tb_top;
  import loop_cal_pkg::*;
  logic mclk, reset_n, cmd_wr, cmd_rd, cmd_rvalid, cmd_unknown, nvm_load, output_enable;
  logic rampup_done, meas_done, inject_en, robust_comp, pole_update, neg_duty_en;
  logic nvm_store_req;
  logic [7:0] cmd_code, bandwidth_pct;
  logic [31:0] cmd_wdata, cmd_rdata, nvm_filter_model, rd;
  logic [15:0] nvm_cal_policy, meas_freq, output_resonance_freq, switching_frequency;
  logic [15:0] loop_gain, damping_ratio_setting;
  cal_state_type cal_state;
  int error_cnt, samples_checked, cycles, n;
  logic [7:0] codes [4] = '{`CMD_CAL_POLICY, `CMD_LOOP_GAIN, `CMD_DAMPING, `CMD_SWITCH_FREQ};
  logic [31:0] resets [4] = '{32'h024B, 32'h0080, 32'h0180, 32'h0258};
  // ramp-up default kept at a thirty-second of the new switching setting
  localparam logic [15:0] fsw_new = 16'h0320;
  logic [31:0] ramp_val = {16'h0000, fsw_new >> 5};

  loop_compensation_calibration #(.INTERVAL_CYCLES(20)) dut_u (.*);
  host_model host_u (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("mismatches=%0d comparisons=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // enable output, check ramp gains, end ramp-up and check where the sequencer went
  task automatic ramp(input cal_state_type exp_st);
    @(posedge mclk) output_enable <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk(robust_comp, 1);
    @(posedge mclk) rampup_done <= 1'b1;
    @(posedge mclk) rampup_done <= 1'b0;
    #1 chk(cal_state, exp_st);
    chk(inject_en, exp_st == ST_MEASURE);
    chk(pole_update, 1);
    chk(robust_comp, 0);
  endtask : ramp

  task automatic measure(input logic [15:0] f, input logic store, input cal_state_type st);
    @(posedge mclk);
    meas_done <= 1'b1;
    meas_freq <= f;
    @(posedge mclk);
    meas_done <= 1'b0;
    meas_freq <= ~f;
    #1 chk(nvm_store_req, store);
    chk(cal_state, st);
    chk(pole_update, 1);
  endtask : measure

  task automatic shut;
    @(posedge mclk) output_enable <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : shut

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard, the whole run takes well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    {reset_n, nvm_load, output_enable, rampup_done, meas_done, meas_freq} = '0;
    nvm_filter_model = 32'h0000_0099;
    nvm_cal_policy   = 16'h004B;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host_u.read_cmd(codes[i], rd);
      chk(rd, resets[i]);
    end
    chk(bandwidth_pct, 8'h0A);
    host_u.read_cmd(8'h10, rd);
    chk(rd, 32'h00000000);
    chk(cmd_unknown, 1);
    host_u.write_cmd(`CMD_LOOP_GAIN, 32'h0100);
    host_u.write_cmd(`CMD_LOOP_OPTIONS, 32'h0001);
    host_u.write_cmd(`CMD_DAMPING, 32'h0200);
    host_u.write_cmd(`CMD_SWITCH_FREQ, {16'h0000, fsw_new});
    repeat (2) @(posedge mclk);
    #1 chk({loop_gain, neg_duty_en}, {16'h0100, 1'b1});
    chk({switching_frequency, damping_ratio_setting}, {fsw_new, 16'h0200});
    // filter model written by command here, before the output is enabled
    host_u.write_cmd(`CMD_FILTER_MODEL, ramp_val);
    host_u.write_cmd(`CMD_CAL_POLICY, 32'h024F);
    ramp(ST_MEASURE);
    chk(output_resonance_freq, ramp_val[15:0]);
    measure(16'h0456, 1'b1, ST_RUN);
    host_u.read_cmd(`CMD_FILTER_MODEL, rd);
    chk(rd, 32'h0456);
    host_u.read_cmd(`CMD_CAL_POLICY, rd);
    chk(rd, 32'h024B);
    shut();
    host_u.read_cmd(`CMD_FILTER_MODEL, rd);
    chk(rd, 32'h0099);
    ramp(ST_MEASURE);
    measure(16'h0457, 1'b0, ST_RUN);
    shut();
    // stored defaults: calibration off, stored resonance value kept
    @(posedge mclk) nvm_load <= 1'b1;
    @(posedge mclk) nvm_load <= 1'b0;
    host_u.read_cmd(`CMD_CAL_POLICY, rd);
    chk(rd, 32'h004B);
    ramp(ST_RUN);
    repeat (40) @(posedge mclk);
    #1 chk({inject_en, output_resonance_freq}, {1'b0, 16'h0099});
    shut();
    // new power-up: calibrate after the first ramp-up only
    @(posedge mclk) reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    host_u.write_cmd(`CMD_CAL_POLICY, 32'h124B);
    chk(switching_frequency, `SWITCH_FREQ_RESET);
    ramp(ST_MEASURE);
    measure(16'h0300, 1'b0, ST_RUN);
    shut();
    ramp(ST_RUN);
    shut();
    // continuous recalibration on the shortened interval
    host_u.write_cmd(`CMD_CAL_POLICY, 32'h034B);
    ramp(ST_MEASURE);
    measure(16'h0310, 1'b0, ST_WAIT);
    n = 0;
    while (inject_en !== 1'b1 && n < 60) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(n >= 15 && n <= 25, 1);
    measure(16'h0320, 1'b0, ST_WAIT);
    host_u.write_cmd(`CMD_CAL_POLICY, 32'h024B);
    repeat (2) @(posedge mclk);
    #1 chk(cal_state, ST_RUN);
    host_u.write_cmd(`CMD_CAL_POLICY, 32'h034B);
    repeat (2) @(posedge mclk);
    #1 chk(cal_state, ST_WAIT);
    shut();
    conclude();
  end
endmodule : loop_compensation_calibration_tb_top
